// *** src/sfp_pkg.sv ***
// constants, states and carrier structs for the supply fault protection sequencer
package sfp_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned LATCH_US     = 210;
  localparam int unsigned BROWN_US     = 270;
  localparam int unsigned LREL_US      = 450;
  localparam int unsigned OVLD_MS      = 40;
  localparam int unsigned LATCH_CYC    = (LATCH_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BROWN_CYC    = (BROWN_US * (CLK_HZ / 1_000_000));
  localparam int unsigned LREL_CYC     = (LREL_US * (CLK_HZ / 1_000_000));
  localparam int unsigned OVLD_CYC     = (OVLD_MS * (CLK_HZ / 1_000));
  localparam int unsigned CNT_W        = 20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h0_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 20'h0_0001;

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [2:0] {
    SFP_NORMAL,
    SFP_ODD_SKIP,
    SFP_NON_SWITCH,
    SFP_AUTO_RESTART,
    SFP_BROWNOUT,
    SFP_LATCHED
  } sfp_state_t;

  // comparator indications from the analog front end
  typedef struct packed {
    logic vcc_ovp;        // supply above 25.5 V
    logic otp_trip;       // junction above 130 C
    logic otp_clear;      // junction 50 C below trip point
    logic vcc_above_on;   // supply above 17 V lockout-on level
    logic vcc_above_off;  // supply above 10.5 V lockout-off level
    logic vcc_above_8v;   // supply above 8 V reference-good level
    logic fb_overload;    // feedback above 4.5 V
    logic brl_below_0v4;  // brownout sense below 0.4 V
    logic brl_below_1v;   // brownout sense below 1 V
    logic brl_above_1v25; // brownout sense above 1.25 V
  } sfp_sense_t;

  // status outputs
  typedef struct packed {
    logic gate_en;
    logic softstart;
    logic startup_cell_on;
    logic logic_on;
    logic brownout;
    logic latched;
    logic even_cycle;
  } sfp_status_t;
endpackage

// *** src/sfp_fsm.sv ***
// supply fault protection and restart sequencer
// Functional notes
// - supply over-voltage enters odd-skip auto restart
// - over-temperature enters non-switch auto restart
// - over-temperature release needs 50 C drop
// - latch only after 210 us continuous low
// - latched off holds gate off
// - undervoltage and shorted opto use normal restart
// - below 10.5V logic off, startup cell on
// - at 17V restart; cycle repeats while faulty
// - feedback overload 40 ms enters odd-skip
// - brownout after 270 us below 1V
// - leave brownout above 1.25V
// - brownout detector from 8V; default at startup
// - brownout: no switching, re-evaluate each cycle
// - latch cleared below 8V supply
// - slow 450 us rise 0.4-1V clears latch
// - odd-skip: odd cycles idle, even cycles detect
// - non-switch: even cycles detect without switching
`timescale 1ns/1ps
`default_nettype none
module sfp_fsm
  import sfp_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire sfp_sense_t  i_sense,
  output var sfp_status_t  o_status,
  output var sfp_state_t   o_state
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  sfp_sense_t s1_q;
  sfp_sense_t s2_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= i_sense;
      s2_q <= s1_q;
    end
  end

  // ****************************************************************
  // blanking counters
  // ****************************************************************
  function automatic logic [CNT_W-1:0] blank_next(input logic cond,
                                                  input logic [CNT_W-1:0] cnt,
                                                  input logic [CNT_W-1:0] lim);
    if (!cond) begin
      blank_next = CNT_ZERO;
    end else if (cnt < lim) begin
      blank_next = cnt + CNT_ONE;
    end else begin
      blank_next = cnt;
    end
  endfunction

  logic [CNT_W-1:0] ovl_cnt_q, ovl_cnt_d;
  logic [CNT_W-1:0] lat_cnt_q, lat_cnt_d;
  logic [CNT_W-1:0] bro_cnt_q, bro_cnt_d;
  logic [CNT_W-1:0] rise_cnt_q, rise_cnt_d;
  logic             rising_q, rising_d;
  logic             ovl_hit, lat_hit, bro_hit;
  logic             slow_rise;

  always_comb begin
    ovl_cnt_d = blank_next(s2_q.fb_overload && o_state == SFP_NORMAL,
                           ovl_cnt_q, CNT_W'(OVLD_CYC));
    lat_cnt_d = blank_next(s2_q.brl_below_0v4, lat_cnt_q, CNT_W'(LATCH_CYC));
    // brownout qualification, only above 8 V
    bro_cnt_d = blank_next(s2_q.brl_below_1v && s2_q.vcc_above_8v,
                           bro_cnt_q, CNT_W'(BROWN_CYC));
    // time the rise from 0.4 V to 1 V
    rising_d   = rising_q;
    rise_cnt_d = rise_cnt_q;
    slow_rise  = 1'b0;
    if (s2_q.brl_below_0v4) begin
      rising_d   = 1'b1;
      rise_cnt_d = CNT_ZERO;
    end else if (rising_q && s2_q.brl_below_1v) begin
      rise_cnt_d = blank_next(1'b1, rise_cnt_q, CNT_W'(LREL_CYC));
    end else if (rising_q) begin
      rising_d  = 1'b0;
      slow_rise = (rise_cnt_q >= CNT_W'(LREL_CYC));
    end
  end

  assign ovl_hit = (ovl_cnt_q >= CNT_W'(OVLD_CYC));
  assign lat_hit = (lat_cnt_q >= CNT_W'(LATCH_CYC));
  assign bro_hit = (bro_cnt_q >= CNT_W'(BROWN_CYC));

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovl_cnt_q  <= CNT_ZERO;
      lat_cnt_q  <= CNT_ZERO;
      bro_cnt_q  <= CNT_ZERO;
      rise_cnt_q <= CNT_ZERO;
      rising_q   <= 1'b0;
    end else begin
      ovl_cnt_q  <= ovl_cnt_d;
      lat_cnt_q  <= lat_cnt_d;
      bro_cnt_q  <= bro_cnt_d;
      rise_cnt_q <= rise_cnt_d;
      rising_q   <= rising_d;
    end
  end

  // ****************************************************************
  // supply on/off and restart cycle tracking
  // ****************************************************************
  logic       on_q, on_d;
  logic       odd_q, odd_d;
  logic       otp_hold_q, otp_hold_d;
  logic       cycle_start;
  sfp_state_t st_q, st_d;

  always_comb begin
    on_d        = on_q;
    odd_d       = odd_q;
    cycle_start = 1'b0;
    // below lockout-off the logic turns off
    if (!s2_q.vcc_above_off) begin
      on_d = 1'b0;
    // recharged to lockout-on, new restart cycle
    end else if (!on_q && s2_q.vcc_above_on) begin
      on_d        = 1'b1;
      cycle_start = 1'b1;
      odd_d       = !odd_q;
    end
    otp_hold_d = otp_hold_q;
    if (s2_q.otp_trip) begin
      otp_hold_d = 1'b1;
    end else if (s2_q.otp_clear) begin
      otp_hold_d = 1'b0;
    end
  end

  // ****************************************************************
  // protection state machine
  // ****************************************************************
  logic fault_odd;
  logic even_now;

  assign fault_odd = s2_q.vcc_ovp || ovl_hit;
  assign even_now  = !odd_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      SFP_NORMAL: begin
        if (fault_odd) begin
          st_d = SFP_ODD_SKIP;
        end else if (otp_hold_q) begin
          st_d = SFP_NON_SWITCH;
        end else if (!on_q) begin
          st_d = SFP_AUTO_RESTART;
        end
      end
      // odd-skip release only on even cycle
      SFP_ODD_SKIP: begin
        if (cycle_start && !odd_d && !s2_q.vcc_ovp) begin
          st_d = SFP_NORMAL;
        end
      end
      SFP_NON_SWITCH: begin
        if (cycle_start && !odd_d && !otp_hold_q) begin
          st_d = SFP_NORMAL;
        end
      end
      SFP_AUTO_RESTART: begin
        if (cycle_start) begin
          st_d = SFP_NORMAL;
        end
      end
      // leave brownout above 1.25 V, checked each cycle
      // brownout exit also needs the logic on (on_q)
      SFP_BROWNOUT: begin
        if (on_q && s2_q.brl_above_1v25) begin
          st_d = SFP_NORMAL;
        end
      end
      SFP_LATCHED: begin
        if (slow_rise) begin
          st_d = SFP_BROWNOUT;
        end
      end
      default: st_d = SFP_BROWNOUT;
    endcase
    if (bro_hit && st_d != SFP_LATCHED) begin
      st_d = SFP_BROWNOUT;
    end
    if (!s2_q.vcc_above_on && !on_q && st_q == SFP_BROWNOUT) begin
      st_d = SFP_BROWNOUT;
    end
    // latch has priority over every restart
    if (lat_hit && st_q != SFP_LATCHED) begin
      st_d = SFP_LATCHED;
    end
    // supply below 8 V forces brownout, clearing the latch
    if (!s2_q.vcc_above_8v) begin
      st_d = SFP_BROWNOUT;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q       <= SFP_BROWNOUT;
      on_q       <= 1'b0;
      odd_q      <= 1'b0;
      otp_hold_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      on_q       <= on_d;
      odd_q      <= odd_d;
      otp_hold_q <= otp_hold_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  sfp_status_t stat_d;

  always_comb begin
    stat_d                 = '0;
    stat_d.logic_on        = on_q;
    stat_d.startup_cell_on = !on_q;
    stat_d.brownout        = (st_q == SFP_BROWNOUT);
    stat_d.latched         = (st_q == SFP_LATCHED);
    stat_d.even_cycle      = even_now;
    // lockout-off stops switching in every state
    if (on_q) begin
      case (st_q)
        SFP_NORMAL:       stat_d.gate_en = 1'b1;
        // soft-start pulses on even cycles only
        SFP_ODD_SKIP: begin
          stat_d.gate_en   = even_now;
          stat_d.softstart = even_now;
        end
        SFP_AUTO_RESTART: begin
          stat_d.gate_en   = 1'b1;
          stat_d.softstart = 1'b1;
        end
        default:          stat_d.gate_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status <= '0;
    end else begin
      o_status <= stat_d;
    end
  end

  assign o_state = st_q;

endmodule
`default_nettype wire

// *** verif/sfp_fsm_properties.sv ***
// port assertions for the fault sequencer
`timescale 1ns/1ps
`default_nettype none
module sfp_fsm_properties
  import sfp_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire sfp_sense_t  i_sense,
  input wire sfp_status_t o_status,
  input wire sfp_state_t  o_state
);
  localparam int LAT_MIN = LATCH_CYC - 3;
  logic [CNT_W-1:0] lo_q;
  logic [CNT_W-1:0] lo_d;
  // ****
  // low-time counter on the latch request
  // ****
  always_comb begin
    lo_d = i_sense.brl_below_0v4 ? lo_q + CNT_ONE : CNT_ZERO;
  end
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      lo_q <= CNT_ZERO;
    end else begin
      lo_q <= lo_d;
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  // over-voltage seen in normal running, then held for two more cycles
  sequence s_ovp;
    (o_state == SFP_NORMAL && i_sense.vcc_ovp && !i_sense.brl_below_1v)
    ##1 (i_sense.vcc_ovp && !i_sense.brl_below_1v)[*2];
  endsequence
  // over-temperature needs one more cycle through the thermal hold flop
  sequence s_otp;
    (o_state == SFP_NORMAL && i_sense.otp_trip && !i_sense.vcc_ovp
     && i_sense.vcc_above_8v && !i_sense.brl_below_1v)
    ##1 (i_sense.otp_trip && !i_sense.vcc_ovp && i_sense.vcc_above_8v
         && !i_sense.brl_below_1v)[*3];
  endsequence
  sequence s_bo_up;
    (o_state == SFP_BROWNOUT && i_sense.brl_above_1v25 && i_sense.vcc_above_on)
    ##1 (i_sense.brl_above_1v25 && i_sense.vcc_above_on)[*3];
  endsequence
  property p_ovp;
    s_ovp |=> (o_state == SFP_ODD_SKIP);
  endproperty
  property p_otp;
    s_otp |=> (o_state == SFP_NON_SWITCH);
  endproperty
  property p_ref;
    (!i_sense.vcc_above_8v)[*4] |=> (o_state == SFP_BROWNOUT);
  endproperty
  property p_supply_lockout_threshold;
    (!i_sense.vcc_above_off)[*5] |=> (!o_status.logic_on && o_status.startup_cell_on);
  endproperty
  property p_lat_gate;
    (o_state == SFP_LATCHED)[*2] |=> !o_status.gate_en;
  endproperty
  property p_bo_gate;
    (o_state == SFP_BROWNOUT)[*2] |=> !o_status.gate_en;
  endproperty
  property p_lat_blank;
    (o_state == SFP_LATCHED) && !$stable(o_state) |-> $past(lo_q, 3) >= LAT_MIN;
  endproperty
  property p_bo_exit;
    s_bo_up |=> (o_state == SFP_NORMAL);
  endproperty
  a_ovp: assert property (p_ovp) else $error("ovp missed");
  a_otp: assert property (p_otp) else $error("otp missed");
  a_ref: assert property (p_ref) else $error("low supply kept state");
  a_supply_lockout_threshold: assert property (p_supply_lockout_threshold) else $error("lockout ignored");
  a_lat_gate: assert property (p_lat_gate) else $error("gate on in latch");
  a_bo_gate: assert property (p_bo_gate) else $error("gate on in brownout");
  a_lat_blank: assert property (p_lat_blank) else $error("latch too early");
  a_bo_exit: assert property (p_bo_exit) else $error("brownout kept");
endmodule
bind sfp_fsm sfp_fsm_properties i_props (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sense(i_sense),
  .o_status(o_status), .o_state(o_state));
`default_nettype wire

// *** verif/sfp_sense_model.sv ***
// behavioural comparators of the analog front end
`timescale 1ns/1ps
`default_nettype none
module sfp_sense_model
  import sfp_pkg::*;
(
  input  var int         i_vcc_mv,
  input  var int         i_brl_mv,
  input  var int         i_fb_mv,
  input  var int         i_temp_c,
  output var sfp_sense_t o_sense
);
  always_comb begin
    o_sense.vcc_ovp        = i_vcc_mv > 25500;
    o_sense.otp_trip       = i_temp_c > 130;
    o_sense.otp_clear      = i_temp_c < 80;
    o_sense.vcc_above_on   = i_vcc_mv >= 17000;
    o_sense.vcc_above_off  = i_vcc_mv > 10500;
    o_sense.vcc_above_8v   = i_vcc_mv > 8000;
    o_sense.fb_overload    = i_fb_mv > 4500;
    o_sense.brl_below_0v4  = i_brl_mv < 400;
    o_sense.brl_below_1v   = i_brl_mv < 1000;
    o_sense.brl_above_1v25 = i_brl_mv > 1250;
  end
endmodule
`default_nettype wire

// *** verif/sfp_fsm_bench.sv ***
// self-checking bench for the fault sequencer
`timescale 1ns/1ps
`default_nettype none
module sfp_fsm_bench;
  import sfp_pkg::*;
  logic        i_mclk;
  logic        i_nrst     = 1'b0;
  int          vcc        = 0;
  int          brownout_sense_pin        = 0;
  int          fb         = 0;
  int          temp       = 25;
  int          error_cnt  = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  int          seed       = 32'h0000_453a;
  int          n;
  sfp_sense_t  sense;
  sfp_status_t st;
  sfp_state_t  state;
  sfp_sense_model i_model (.i_vcc_mv(vcc), .i_brl_mv(brownout_sense_pin), .i_fb_mv(fb), .i_temp_c(temp),
    .o_sense(sense));
  sfp_fsm i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sense(sense), .o_status(st),
    .o_state(state));
  // ****
  // tasks
  // ****
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // state expected after a request held for a number of cycles
  function automatic logic [7:0] exp_blank(input int         held,
                                           input int         lim,
                                           input sfp_state_t hit);
    return (held >= lim) ? 8'(hit) : 8'(SFP_NORMAL);
  endfunction
  task automatic hold(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic drv(input int v, input int b, input int t);
    @(posedge i_mclk);
    vcc  <= v;
    brownout_sense_pin  <= b;
    temp <= t;
    fb   <= $unsigned($random(seed)) % 4400;
    #1;
  endtask
  task automatic go(input sfp_state_t s, input int k);
    for (int i = 0; i < k && state !== s; i++) begin
      hold(1);
    end
    check("state", 8'(state), 8'(s));
  endtask
  task automatic restart(input int t);
    drv(9000, 2000, t);
    hold(8);
    check("logic_on", 8'(st.logic_on), 8'h00);
    check("cell_on", 8'(st.startup_cell_on), 8'h01);
    drv(18000, 2000, t);
    hold(8);
  endtask
  task automatic recover();
    for (int i = 0; i < 4 && state !== SFP_NORMAL; i++) begin
      restart(25);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      close_out();
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    hold(16);
    check("rst", 8'(state), 8'(SFP_BROWNOUT));
    check("rst_st", 8'(st), 8'h00);
    i_nrst <= 1'b1;
    drv(12000, 2000, 25);
    hold(40);
    check("startup", 8'(state), 8'(SFP_BROWNOUT));
    drv(18000, 2000, 25);
    go(SFP_NORMAL, 60);
    drv(9000, 2000, 25);
    go(SFP_AUTO_RESTART, 10);
    drv(18000, 2000, 25);
    go(SFP_NORMAL, 60);
    drv(26000, 2000, 25);
    go(SFP_ODD_SKIP, 4);
    hold(2);
    // second cycle since power-up is even: soft-start pulses
    check("ovp_soft", 8'(st.softstart), 8'h01);
    restart(25);
    check("odd_state", 8'(state), 8'(SFP_ODD_SKIP));
    check("odd_gate", 8'(st.gate_en), 8'h00);
    check("odd_soft", 8'(st.softstart), 8'h00);
    recover();
    check("ovp_rel", 8'(state), 8'(SFP_NORMAL));
    check("even", 8'(st.even_cycle), 8'h01);
    drv(18000, 2000, 140);
    go(SFP_NON_SWITCH, 4);
    restart(100);
    restart(100);
    check("otp_hys", 8'(state), 8'(SFP_NON_SWITCH));
    check("ns_gate", 8'(st.gate_en), 8'h00);
    recover();
    check("otp_rel", 8'(state), 8'(SFP_NORMAL));
    @(posedge i_mclk);
    fb <= 4600;
    hold(2000);
    check("ovl_blank", 8'(state), 8'(SFP_NORMAL));
    n = 100 + $unsigned($random(seed)) % 3000;
    drv(18000, 200, 25);
    hold(n);
    drv(18000, 2000, 25);
    hold(10);
    check("short", 8'(state), exp_blank(n, int'(LATCH_CYC), SFP_LATCHED));
    drv(18000, 200, 25);
    hold(LATCH_CYC - 5);
    check("blank", 8'(state),
          exp_blank(int'(LATCH_CYC) - 5, int'(LATCH_CYC), SFP_LATCHED));
    go(SFP_LATCHED, 20);
    hold(2);
    check("lat_gate", 8'(st.gate_en), 8'h00);
    check("lat_flag", 8'(st.latched), 8'h01);
    drv(18000, 700, 25);
    hold(2000);
    drv(18000, 2000, 25);
    hold(20);
    check("fast", 8'(state), 8'(SFP_LATCHED));
    drv(18000, 200, 25);
    hold(10);
    drv(18000, 700, 25);
    hold(LREL_CYC + 20);
    drv(18000, 2000, 25);
    go(SFP_NORMAL, 60);
    drv(18000, 200, 25);
    go(SFP_LATCHED, LATCH_CYC + 20);
    drv(5000, 2000, 25);
    hold(8);
    check("clr8v", 8'(state), 8'(SFP_BROWNOUT));
    drv(18000, 2000, 25);
    go(SFP_NORMAL, 60);
    drv(18000, 700, 25);
    hold(n);
    drv(18000, 2000, 25);
    hold(10);
    check("bo_short", 8'(state), exp_blank(n, int'(BROWN_CYC), SFP_BROWNOUT));
    drv(18000, 700, 25);
    hold(BROWN_CYC - 5);
    check("bo_blank", 8'(state),
          exp_blank(int'(BROWN_CYC) - 5, int'(BROWN_CYC), SFP_BROWNOUT));
    go(SFP_BROWNOUT, 20);
    drv(18000, 1100, 25);
    hold(20);
    check("bo_gate", 8'(st.gate_en), 8'h00);
    check("bo_flag", 8'(st.brownout), 8'h01);
    check("bo_hys", 8'(state), 8'(SFP_BROWNOUT));
    drv(18000, 2000, 25);
    go(SFP_NORMAL, 20);
    close_out();
  end
endmodule
`default_nettype wire
